// [logic/status_irq_consts.svh]
// Offsets, field positions, reset values and sizes of the status and interrupt block.
// Included by the package and the design; defines only.
`ifndef STATUS_IRQ_CONSTS_SVH
`define STATUS_IRQ_CONSTS_SVH

`define N_SRC          13
`define N_REF          4
`define SEL_W          5
`define ADDR_W         8

`define REG_CTRL       8'h00
`define REG_POL        8'h04
`define REG_EN         8'h08
`define REG_FLAGS      8'h0c
`define REG_LIVE       8'h10
`define REG_CLR        8'h14
`define REG_PIN_BASE   8'h18

`define CTRL_ENABLE    0
`define CTRL_AND_MODE  1
`define CTRL_CLEAR     2
`define LIVE_WIN_LSB   16
`define PIN_OD_BIT     8
`define PIN_INV_BIT    9

`define SEL_WIN_BASE   5'h0d
`define SEL_IRQ        5'h11
`define SEL_COUNT      5'h12

`define CTRL_RESET     2'h0
`define POL_RESET      13'h1fff
`define EN_RESET       13'h0000
`define PIN_RESET      10'h000

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// [logic/status_irq_pkg.sv]
// Types shared by the status and interrupt block and its users.
// Assumes status_irq_consts.svh is on the include path.
`include "status_irq_consts.svh"

package status_irq_pkg;
   typedef logic [`N_SRC-1:0] src_vec_type;
   typedef logic [`N_REF-1:0] ref_vec_type;
   typedef logic [`SEL_W-1:0] pin_sel_type;
   typedef enum logic {DRIVE_PUSH_PULL, DRIVE_OPEN_DRAIN} drive_type;
endpackage

// [logic/status_interrupt_logic.sv]
// Status routing and interrupt aggregation, reached over AXI4-Lite.
// Assumes one clock aclk; live status inputs may come from other domains.
//
// Contract
// - Each pin drives a chosen status, with programmable driver type and polarity.
// - Any pin may carry the device interrupt; its logic is set by registers.
// - The interrupt output asserts only while the interrupt enable is set.
// - Sources: oscillator loss, reference loss, PLL unlock, holdover, switchover.
// - Polarity high sets the sticky flag on a rising live status edge.
// - Polarity low sets the sticky flag on a falling live status edge.
// - Each flag has its own mask; masked flags record but never interrupt.
// - Unmasked flags combine through a selectable AND or OR into one output.
// - The combined interrupt is routable to either status pin by software.
// - Writing one to the clear field deasserts the output; field reads zero.
// - Missing and runt pulse flags per reference are ORed into one indication.
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "status_irq_consts.svh"

module status_interrupt_logic #(
   parameter int N_GPIO = 2
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic                        ce,
   input  wire logic                        osc_signal_missing,
   input  wire logic                        reference_input_lost,
   input  wire logic [1:0]                  apll_unlocked,
   input  wire logic [2:0]                  dpll_unlocked,
   input  wire logic [2:0]                  dpll_holdover,
   input  wire logic [2:0]                  dpll_switchover,
   input  wire status_irq_pkg::ref_vec_type ref_missing_pulse,
   input  wire status_irq_pkg::ref_vec_type ref_runt_pulse,
   input  wire logic [`ADDR_W-1:0]          awaddr,
   input  wire logic                        awvalid,
   output logic                             awready,
   input  wire logic [31:0]                 wdata,
   input  wire logic [3:0]                  wstrb,
   input  wire logic                        wvalid,
   output logic                             wready,
   output logic [1:0]                       bresp,
   output logic                             bvalid,
   input  wire logic                        bready,
   input  wire logic [`ADDR_W-1:0]          araddr,
   input  wire logic                        arvalid,
   output logic                             arready,
   output logic [31:0]                      rdata,
   output logic [1:0]                       rresp,
   output logic                             rvalid,
   input  wire logic                        rready,
   output logic                             irq_out,
   output status_irq_pkg::ref_vec_type      window_detect_flag,
   output logic [N_GPIO-1:0]                gpio_out,
   output logic [N_GPIO-1:0]                gpio_oe_n
);
   import status_irq_pkg::*;

   src_vec_type       live;
   src_vec_type       sync1_reg;
   src_vec_type       sync2_reg;
   src_vec_type       prev_reg;
   ref_vec_type       win_sync1_reg;
   ref_vec_type       win_sync2_reg;
   src_vec_type       rise;
   src_vec_type       fall;
   src_vec_type       set_vec;
   src_vec_type       clr_vec;
   src_vec_type       flags_reg;
   src_vec_type       flags_next;
   src_vec_type       pol_reg;
   src_vec_type       en_reg;
   logic [1:0]        ctrl_reg;
   logic              irq_next;
   logic [9:0]        pin_cfg_reg [N_GPIO];
   logic [N_GPIO-1:0] pin_hit_w;
   logic [N_GPIO-1:0] pin_hit_r;
   logic [`SEL_COUNT-1:0] pin_src;
   logic              wr_take;
   logic              rd_take;
   logic              wr_ok;
   logic              rd_ok;
   logic [31:0]       rd_mux;
   logic [31:0]       wmask;

   ////////////////////////////////////////////////////////////////////////////
   // Source capture

   assign live = {dpll_switchover, dpll_holdover, dpll_unlocked, apll_unlocked,
                  reference_input_lost, osc_signal_missing};

   // two-stage synchronisers, edge taken after the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
      end else if (ce) begin
         sync1_reg <= live;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // missing and runt flags merged before the synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         win_sync1_reg <= '0;
         win_sync2_reg <= '0;
      end else if (ce) begin
         win_sync1_reg <= ref_missing_pulse | ref_runt_pulse;
         win_sync2_reg <= win_sync1_reg;
      end
   end
   assign window_detect_flag = win_sync2_reg;

   // rising edge when polarity is high
   assign rise = sync2_reg & ~prev_reg;
   // falling edge when polarity is low
   assign fall = ~sync2_reg & prev_reg;
   assign set_vec = (rise & pol_reg) | (fall & ~pol_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   // Both write channels are taken together; a pending response blocks new ones
   assign awready = ce & ~bvalid & awvalid & wvalid;
   assign wready  = awready;
   assign arready = ce & ~rvalid;
   assign wr_take = awready;
   assign rd_take = arready & arvalid;
   assign wmask   = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

   always_comb begin
      for (int i = 0; i < N_GPIO; i++) begin
         pin_hit_w[i] = (awaddr == `ADDR_W'(`REG_PIN_BASE + 4 * i));
         pin_hit_r[i] = (araddr == `ADDR_W'(`REG_PIN_BASE + 4 * i));
      end
   end

   assign wr_ok = (awaddr == `REG_CTRL) || (awaddr == `REG_POL) || (awaddr == `REG_EN)
                  || (awaddr == `REG_CLR) || (|pin_hit_w);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (wr_take) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // enable and AND/OR choice held in the control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (ce && wr_take && awaddr == `REG_CTRL && wstrb[0]) begin
         ctrl_reg <= wdata[`CTRL_AND_MODE:`CTRL_ENABLE];
      end
   end

   // polarity and enables return to defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pol_reg <= `POL_RESET;
         en_reg  <= `EN_RESET;
      end else if (ce && wr_take) begin
         if (awaddr == `REG_POL) begin
            pol_reg <= (pol_reg & ~wmask[`N_SRC-1:0]) | (wdata[`N_SRC-1:0] & wmask[`N_SRC-1:0]);
         end
         if (awaddr == `REG_EN) begin
            en_reg <= (en_reg & ~wmask[`N_SRC-1:0]) | (wdata[`N_SRC-1:0] & wmask[`N_SRC-1:0]);
         end
      end
   end

   // per-pin source, driver type and inversion
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N_GPIO; i++) begin
            pin_cfg_reg[i] <= `PIN_RESET;
         end
      end else if (ce && wr_take) begin
         for (int i = 0; i < N_GPIO; i++) begin
            if (pin_hit_w[i]) begin
               pin_cfg_reg[i] <= (pin_cfg_reg[i] & ~wmask[9:0]) | (wdata[9:0] & wmask[9:0]);
            end
         end
      end
   end

   always_comb begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (araddr)
         `REG_CTRL:  rd_mux[1:0] = ctrl_reg;
         `REG_POL:   rd_mux[`N_SRC-1:0] = pol_reg;
         `REG_EN:    rd_mux[`N_SRC-1:0] = en_reg;
         `REG_FLAGS: rd_mux[`N_SRC-1:0] = flags_reg;
         `REG_LIVE:  rd_mux = {12'h000, win_sync2_reg, 3'h0, sync2_reg};
         `REG_CLR:   rd_mux = 32'h0000_0000;
         default:    rd_ok = |pin_hit_r;
      endcase
      for (int i = 0; i < N_GPIO; i++) begin
         if (pin_hit_r[i]) begin
            rd_mux[9:0] = pin_cfg_reg[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (rd_take) begin
            rvalid <= 1'b1;
            rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
            rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags and interrupt

   // clear strobe wipes all flags and is never stored
   always_comb begin
      clr_vec = '0;
      if (wr_take && awaddr == `REG_CTRL && wstrb[0] && wdata[`CTRL_CLEAR]) begin
         clr_vec = '1;
      end else if (wr_take && awaddr == `REG_CLR) begin
         clr_vec = wdata[`N_SRC-1:0] & wmask[`N_SRC-1:0];
      end
   end

   // A new edge in the clearing cycle survives: set wins over clear
   assign flags_next = (flags_reg & ~clr_vec) | set_vec;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_reg <= '0;
      end else if (ce) begin
         flags_reg <= flags_next;
      end
   end

   // masked flags drop out of both reductions
   // AND needs at least one enabled flag so a full mask never fires
   always_comb begin
      if (ctrl_reg[`CTRL_AND_MODE]) begin
         irq_next = (&(flags_next | ~en_reg)) & (|en_reg);
      end else begin
         irq_next = |(flags_next & en_reg);
      end
      irq_next = irq_next & ctrl_reg[`CTRL_ENABLE];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_out <= 1'b0;
      end else if (ce) begin
         irq_out <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status pins

   // the interrupt is one selectable pin source
   assign pin_src = {irq_out, win_sync2_reg, sync2_reg};

   // any pin may take the interrupt; open drain releases on a one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gpio_out  <= '0;
         gpio_oe_n <= '0;
      end else if (ce) begin
         for (int i = 0; i < N_GPIO; i++) begin
            logic lvl;
            lvl = pin_cfg_reg[i][`PIN_INV_BIT];
            if (pin_cfg_reg[i][`SEL_W-1:0] < `SEL_COUNT) begin
               lvl = pin_src[pin_cfg_reg[i][`SEL_W-1:0]] ^ pin_cfg_reg[i][`PIN_INV_BIT];
            end
            if (drive_type'(pin_cfg_reg[i][`PIN_OD_BIT]) == DRIVE_OPEN_DRAIN) begin
               gpio_out[i]  <= 1'b0;
               gpio_oe_n[i] <= lvl;
            end else begin
               gpio_out[i]  <= lvl;
               gpio_oe_n[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_irq_needs_enable: assert property (
      ce && !ctrl_reg[`CTRL_ENABLE] |=> !irq_out)
      else $error("interrupt asserted while disabled");

   a_rise_sets_flag: assert property (
      ce && |(rise & pol_reg) |=> ((flags_reg & $past(rise & pol_reg)) == $past(rise & pol_reg)))
      else $error("rising edge did not set flag");

   a_fall_sets_flag: assert property (
      ce && |(fall & ~pol_reg) |=> ((flags_reg & $past(fall & ~pol_reg))
                                    == $past(fall & ~pol_reg)))
      else $error("falling edge did not set flag");

   a_masked_quiet: assert property (
      ce && !ctrl_reg[`CTRL_AND_MODE] && ((flags_next & en_reg) == '0) |=> !irq_out)
      else $error("masked flag raised interrupt");

   a_and_reduce: assert property (
      ce && ctrl_reg[`CTRL_ENABLE] && ctrl_reg[`CTRL_AND_MODE] && |en_reg
      && (&(flags_next | ~en_reg)) |=> irq_out)
      else $error("AND reduction did not assert");

   a_clear_strobe: assert property (
      ce && wr_take && awaddr == `REG_CTRL && wstrb[0] && wdata[`CTRL_CLEAR]
      |=> flags_reg == $past(set_vec))
      else $error("clear strobe left stale flags");

   a_pin_routes_irq: assert property (
      ce && pin_cfg_reg[0] == {2'b00, 3'b000, `SEL_IRQ} |=> gpio_out[0] == $past(irq_out))
      else $error("interrupt not routed to pin");

   a_reset_clears: assert property (
      disable iff (1'b0) !aresetn |=> flags_reg == '0 && !irq_out)
      else $error("reset left flags or interrupt");

   a_single_set: assert property (
      ce ##1 ce |-> (set_vec & $past(set_vec)) == '0)
      else $error("one edge set a flag twice");

   c_or_irq:  cover property (ce && !ctrl_reg[`CTRL_AND_MODE] ##1 $rose(irq_out));
   c_and_irq: cover property (ce && ctrl_reg[`CTRL_AND_MODE] ##1 $rose(irq_out));
   c_clear:   cover property (irq_out && |clr_vec ##1 !irq_out);
   c_od_pin:  cover property (gpio_oe_n[0]);

endmodule

// [test/host_model.sv]
// Host side: an AXI4-Lite master that services the interrupt block.
// Assumes its tasks are called from one bench process, one transfer at a time.
`timescale 1ns/1ps
`include "status_irq_consts.svh"

module host_model (
   input  wire logic              aclk,
   output logic [`ADDR_W-1:0]     awaddr,
   output logic                   awvalid,
   input  wire logic              awready,
   output logic [31:0]            wdata,
   output logic [3:0]             wstrb,
   output logic                   wvalid,
   input  wire logic              wready,
   input  wire logic              bvalid,
   output logic                   bready,
   output logic [`ADDR_W-1:0]     araddr,
   output logic                   arvalid,
   input  wire logic              arready,
   input  wire logic              rvalid,
   output logic                   rready,
   output logic                   stuck
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, stuck} = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads and writes, one transfer per call
   task automatic write(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         // Released lines carry garbage so a late sample cannot look right
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end while (!bvalid && n < 100);
      // Response ready stays up between writes, so that a second call in the same step does not
      // assign it twice
      if (n >= 100) stuck <= 1'b1;
   endtask

   task automatic read(input logic [`ADDR_W-1:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) begin
            arvalid <= 1'b0;
            araddr <= ~a;
         end
      end while (!rvalid && n < 100);
      // Read ready stays up between reads for the same reason
      if (n >= 100) stuck <= 1'b1;
   endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the status and interrupt block.
// Assumes host_model drives the register bus; reads are checked by a monitor.
`timescale 1ns/1ps
`include "status_irq_consts.svh"

module testbench;
   import status_irq_pkg::*;
   logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq_out, stuck;
   logic [`ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, gpio_out, gpio_oe_n;
   src_vec_type live;
   ref_vec_type miss, runt, window_detect_flag;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int n_mismatch, checked;

   status_interrupt_logic i_status_interrupt_logic (.aclk, .aresetn, .ce,
      .osc_signal_missing(live[0]), .reference_input_lost(live[1]),
      .apll_unlocked(live[3:2]), .dpll_unlocked(live[6:4]), .dpll_holdover(live[9:7]),
      .dpll_switchover(live[12:10]), .ref_missing_pulse(miss), .ref_runt_pulse(runt),
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_out,
      .window_detect_flag, .gpio_out, .gpio_oe_n);

   host_model i_host_model (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready, .stuck);

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results;
      $display("counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back(r);
      i_host_model.write(a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      i_host_model.read(a);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Monitor: each answer takes the oldest note
   always @(posedge aclk) begin
      if (rvalid && rready) begin
         if (rq.size() == 0) check("read extra", 34'h0, {rresp, rdata});
         else check("read word", rq.pop_front(), {rresp, rdata});
      end
      if (bvalid && bready) begin
         if (bq.size() == 0) check("write extra", 34'h0, {32'h0, bresp});
         else check("write resp", {32'h0, bq.pop_front()}, {32'h0, bresp});
      end
   end

   always @(posedge stuck) begin
      n_mismatch++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [12:0] r;
      aresetn = 1'b0;
      ce = 1'b1;
      live = '0;
      miss = '0;
      runt = '0;
      n_mismatch = 0;
      checked = 0;
      void'($urandom(32'h04f2));
      // Bit 0 forced set for the OR-mode hit and bit 12 forced clear for the AND-mode miss
      r = (13'($urandom()) & 13'h0fff) | 13'h0001;
      tick(8);
      aresetn <= 1'b1;
      tick(1);
      rd(`REG_CTRL, 32'h0, `RESP_OKAY);
      rd(`REG_POL, 32'h1fff, `RESP_OKAY);
      rd(`REG_EN, 32'h0, `RESP_OKAY);
      rd(`REG_FLAGS, 32'h0, `RESP_OKAY);
      rd(`REG_PIN_BASE, 32'h0, `RESP_OKAY);
      rd(8'h40, 32'h0, `RESP_SLVERR);
      wr(`REG_FLAGS, 32'h1, `RESP_SLVERR);
      check("irq after reset", 34'h0, {33'h0, irq_out});
      $display("reset test done");

      live <= r;
      tick(6);
      rd(`REG_FLAGS, {19'h0, r}, `RESP_OKAY);
      rd(`REG_LIVE, {19'h0, r}, `RESP_OKAY);
      wr(`REG_CLR, 32'h1fff, `RESP_OKAY);
      tick(6);
      rd(`REG_FLAGS, 32'h0, `RESP_OKAY);
      wr(`REG_POL, 32'h0, `RESP_OKAY);
      live <= '0;
      tick(6);
      rd(`REG_FLAGS, {19'h0, r}, `RESP_OKAY);
      $display("edge test done");

      wr(`REG_CTRL, 32'h1, `RESP_OKAY);
      tick(3);
      check("irq all masked", 34'h0, {33'h0, irq_out});
      wr(`REG_EN, 32'h1, `RESP_OKAY);
      tick(3);
      check("irq or mode", 34'h1, {33'h0, irq_out});
      wr(`REG_CTRL, 32'h0, `RESP_OKAY);
      tick(3);
      check("irq disabled", 34'h0, {33'h0, irq_out});
      wr(`REG_CTRL, 32'h3, `RESP_OKAY);
      wr(`REG_EN, {19'h0, r | 13'h1000}, `RESP_OKAY);
      tick(3);
      check("irq and miss", 34'h0, {33'h0, irq_out});
      wr(`REG_EN, {19'h0, r}, `RESP_OKAY);
      wr(`REG_PIN_BASE, {27'h0, `SEL_IRQ}, `RESP_OKAY);
      tick(3);
      check("irq and hit", 34'h1, {33'h0, irq_out});
      check("pin0 irq", 34'h1, {32'h0, gpio_oe_n[0], gpio_out[0]});
      rd(`REG_FLAGS, {19'h0, r}, `RESP_OKAY);
      wr(`REG_CTRL, 32'h7, `RESP_OKAY);
      tick(1);
      check("irq cleared", 34'h0, {33'h0, irq_out});
      rd(`REG_CTRL, 32'h3, `RESP_OKAY);
      rd(`REG_FLAGS, 32'h0, `RESP_OKAY);
      $display("interrupt test done");

      // Inverted open drain: a high window flag pulls the pin low
      wr(`REG_PIN_BASE + 8'h04, {22'h0, 2'h3, 3'h0, `SEL_WIN_BASE}, `RESP_OKAY);
      miss <= 4'($urandom()) | 4'h1;
      tick(6);
      check("pin1 pulls low", 34'h0, {32'h0, gpio_oe_n[1], gpio_out[1]});
      miss <= '0;
      runt <= 4'h1;
      tick(6);
      check("window runt", 34'h1, {30'h0, window_detect_flag});
      runt <= '0;
      tick(6);
      check("window clear", 34'h0, {30'h0, window_detect_flag});
      check("pin1 released", 34'h2, {32'h0, gpio_oe_n[1], gpio_out[1]});
      $display("pin test done");
      tick(4);
      results();
   end
endmodule
